// ### design/err_chk.sv
// parity and packet crc checking for a two-wire bus target
`timescale 1ns/1ps
// Behaviour
// - check odd parity except select byte
// - no crc: parity error drops bytes until stop
// - parity error sets status bits, pending 0001
// - read data: no parity, tbit continue/end
// - clean read: ack repeated start, return data
// - read: first byte error discards second too
// - after read error nack every repeated start
// - crc write: execute only on match
// - crc write: parity error drops whole packet
// - read: check crc up to repeated start
// - read: crc over select and sent data
// - only last acked select code in crc
// - read crc error: drop, refuse, flag
// - common commands handled the same way
// - latch errors, report by read/header/interrupt
// - decode command only in i3c with crc
// - command bits 7:5, rw 4, address 5:0
// - 000 one byte, 001+1 two-byte read
// - crc-8 poly 07, zero seed
// - odd parity transition bit
// - i3c entry: parity on, crc off; here both just follow cfg par_en and pec_en
module err_chk (
	input wire logic clk_sys, // system clock
	input wire logic sys_rst, // sync reset, high
	input wire logic link_clk, // bus-side clock
	input wire err_chk_pkg::cfg_t cfg, // mode and enables, system domain
	input wire logic bus_idle, // scl and sda idle, pin level
	input wire logic ibi_en, // in-band interrupt enabled
	input wire logic ibi_done, // pulse: interrupt payload sent
	input wire logic clr_misc, // pulse: clear error status
	input wire logic ev_start, // start seen
	input wire logic ev_rstart, // repeated start seen
	input wire logic ev_stop, // stop seen
	input wire logic rx_valid, // byte received
	input wire logic [7:0] rx_byte, // received byte
	input wire logic rx_tbit, // received transition bit
	input wire logic tx_valid, // byte being sent
	input wire logic [7:0] tx_byte, // sent byte
	input wire logic tx_last, // last data byte
	output logic sel_resp_q, // pulse: select answered
	output logic sel_ack_q, // ack (1) or nack (0)
	output err_chk_pkg::exec_t exec_q, // execute pulse with command
	output logic tbit_q, // transition bit to drive
	output logic [7:0] pec_byte_q, // running crc to append
	output logic hdr_seen_q, // pulse: broadcast header
	output logic [1:0] misc_error_status_reg_q, // crc, parity error
	output logic dev_ibi_status_q, // device status bit 7
	output logic [3:0] pend_q, // pending interrupt bits
	output logic ibi_req_q // ask for interrupt
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] b);
		logic [7:0] c;
		c = crc ^ b;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ err_chk_pkg::CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8_step

	function automatic logic odd_tbit(input logic [7:0] b);
		return ~(^b);
	endfunction : odd_tbit

	// ----------------------------------------------------------------
	// link-side reset and configuration crossing
	// ----------------------------------------------------------------
	logic lrst_meta_q, lrst_q;
	err_chk_pkg::cfg_t cfg_meta_q, cfg_l_q;
	// reset reaches the link only while its clock runs; frames start it
	always_ff @(posedge link_clk) begin
		lrst_meta_q <= sys_rst;
		lrst_q <= lrst_meta_q;
		cfg_meta_q <= cfg;
		cfg_l_q <= cfg_meta_q;
	end

	// ----------------------------------------------------------------
	// link state
	// ----------------------------------------------------------------
	err_chk_pkg::link_st_t st_q, st_d;
	logic [7:0] crc_q, crc_d;
	logic [1:0] idx_q;
	logic drop_q, rd_pend_q, pec_seen_q, par_tog_q, pec_tog_q;
	logic [5:0] addr_q;

	wire crc_on = cfg_l_q.i3c_mode & cfg_l_q.pec_en;
	wire par_on = cfg_l_q.i3c_mode & cfg_l_q.par_en;
	wire is_sel = rx_valid & (idx_q == err_chk_pkg::IDX_SEL);
	wire par_bad = rx_valid & ~is_sel & par_on & (rx_tbit != odd_tbit(rx_byte));
	wire rx_crc_ok = (crc_q == err_chk_pkg::CRC_SEED); // residue of data plus code is zero
	wire rd_bad = drop_q | (crc_on & ~rx_crc_ok);
	// a frame too short to carry a command (a lone header) is not a write
	wire wr_go = ev_stop & (st_q == err_chk_pkg::ST_RX) & ~rd_pend_q & (idx_q == err_chk_pkg::IDX_MAX);
	wire wr_pec_bad = wr_go & crc_on & ~drop_q & ~rx_crc_ok;
	wire rs_bad = ev_rstart & (st_q == err_chk_pkg::ST_RX) & rd_bad;
	wire sel_after_rs = is_sel & rd_pend_q;
	wire [2:0] rx_cmd = rx_byte[err_chk_pkg::CMD_HI:err_chk_pkg::CMD_LO];
	wire rx_rw = rx_byte[err_chk_pkg::CMD_RW_BIT];

	// next state of the frame sequencer
	always_comb begin
		st_d = st_q;
		if (ev_start) begin
			st_d = err_chk_pkg::ST_RX;
		end else if (ev_stop) begin
			st_d = err_chk_pkg::ST_IDLE;
		end else if (rs_bad) begin
			st_d = err_chk_pkg::ST_REFUSE;
		end else if (ev_rstart && st_q == err_chk_pkg::ST_TX) begin
			st_d = err_chk_pkg::ST_RX; // further read after a finished one
		end else if (sel_after_rs && st_q == err_chk_pkg::ST_RX) begin
			st_d = err_chk_pkg::ST_TX;
		end
	end

	// crc: restart at start and at every repeated start, so nacked selects drop out
	always_comb begin
		crc_d = crc_q;
		if (ev_start || ev_rstart) begin
			crc_d = err_chk_pkg::CRC_SEED;
		end else if (rx_valid && st_q != err_chk_pkg::ST_REFUSE) begin
			crc_d = crc8_step(crc_q, rx_byte);
		end else if (tx_valid && st_q == err_chk_pkg::ST_TX) begin
			crc_d = crc8_step(crc_q, tx_byte);
		end
	end

	// frame bookkeeping
	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			st_q <= err_chk_pkg::ST_IDLE;
			crc_q <= err_chk_pkg::CRC_SEED;
			idx_q <= err_chk_pkg::IDX_SEL;
			drop_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 6'h00;
		end else begin
			st_q <= st_d;
			crc_q <= crc_d;
			if (ev_start || ev_rstart) begin
				idx_q <= err_chk_pkg::IDX_SEL;
			end else if (rx_valid && idx_q != err_chk_pkg::IDX_MAX) begin
				idx_q <= idx_q + 2'h1;
			end
			if (ev_start) begin
				drop_q <= 1'b0;
			end else if (par_bad) begin
				drop_q <= 1'b1;
			end
			if (ev_start || ev_stop) begin
				rd_pend_q <= 1'b0;
			end else if (ev_rstart) begin
				rd_pend_q <= 1'b1;
			end
			if (rx_valid && idx_q == err_chk_pkg::IDX_ADDR) begin
				addr_q <= rx_byte[err_chk_pkg::ADDR_HI:0];
			end
		end
	end

	// error events leave the link as toggles; crc error flagged once per frame
	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			par_tog_q <= 1'b0;
			pec_tog_q <= 1'b0;
			pec_seen_q <= 1'b0;
		end else begin
			if (par_bad && !drop_q) begin
				par_tog_q <= ~par_tog_q;
			end
			if (ev_start) begin
				pec_seen_q <= 1'b0;
			end else if ((rs_bad && crc_on && !drop_q && !rx_crc_ok) || wr_pec_bad) begin
				pec_seen_q <= 1'b1;
			end
			if (!pec_seen_q && ((rs_bad && crc_on && !drop_q && !rx_crc_ok) || wr_pec_bad)) begin
				pec_tog_q <= ~pec_tog_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// link outputs
	// ----------------------------------------------------------------
	wire wr_exec = wr_go & ~drop_q & (~crc_on | rx_crc_ok);
	wire rd_exec = sel_after_rs & (st_q == err_chk_pkg::ST_RX);
	// select answer, execute strobe, read-side transition bit and crc
	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			sel_resp_q <= 1'b0;
			sel_ack_q <= 1'b0;
			exec_q <= '0;
			tbit_q <= 1'b0;
			pec_byte_q <= err_chk_pkg::CRC_SEED;
			hdr_seen_q <= 1'b0;
		end else begin
			sel_resp_q <= sel_after_rs;
			if (sel_after_rs) begin
				sel_ack_q <= (st_q == err_chk_pkg::ST_RX);
			end
			exec_q.valid <= wr_exec | rd_exec;
			exec_q.write <= wr_exec;
			exec_q.addr <= addr_q;
			if (ev_start) begin
				exec_q.cmd <= err_chk_pkg::CMD_ONE_BYTE; // short frames keep no stale code
			end else if (rx_valid && idx_q == err_chk_pkg::IDX_CMD) begin
				exec_q.cmd <= crc_on ? rx_cmd : err_chk_pkg::CMD_ONE_BYTE;
			end
			if (tx_valid) begin
				tbit_q <= ~tx_last;
			end
			pec_byte_q <= crc_d;
			hdr_seen_q <= is_sel & (rx_byte[7:1] == err_chk_pkg::IBI_HDR_ADDR);
		end
	end
	wire unused_rw = rx_rw;

	// ----------------------------------------------------------------
	// system side: event crossing and latched status
	// ----------------------------------------------------------------
	logic [2:0] par_s_q, pec_s_q;
	logic [1:0] idle_s_q;
	logic [7:0] avail_q;
	// first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		par_s_q <= {par_s_q[1:0], par_tog_q};
		pec_s_q <= {pec_s_q[1:0], pec_tog_q};
		idle_s_q <= {idle_s_q[0], bus_idle};
	end
	wire par_ev = par_s_q[2] ^ par_s_q[1];
	wire pec_ev = pec_s_q[2] ^ pec_s_q[1];
	wire any_ev = par_ev | pec_ev;
	wire avail_done = (avail_q == err_chk_pkg::AVAIL_LAST);

	// set wins over clear on every flag
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			misc_error_status_reg_q <= 2'b00;
			dev_ibi_status_q <= 1'b0;
			pend_q <= err_chk_pkg::PEND_NONE;
			avail_q <= 8'h00;
			ibi_req_q <= 1'b0;
		end else begin
			misc_error_status_reg_q[err_chk_pkg::MISC_PAR_BIT] <=
				par_ev | (misc_error_status_reg_q[err_chk_pkg::MISC_PAR_BIT] & ~clr_misc);
			misc_error_status_reg_q[err_chk_pkg::MISC_PEC_BIT] <=
				pec_ev | (misc_error_status_reg_q[err_chk_pkg::MISC_PEC_BIT] & ~clr_misc);
			dev_ibi_status_q <= any_ev | (dev_ibi_status_q & ~ibi_done & ~clr_misc);
			pend_q <= any_ev ? err_chk_pkg::PEND_ERR :
				((ibi_done | clr_misc) ? err_chk_pkg::PEND_NONE : pend_q);
			avail_q <= !idle_s_q[1] ? 8'h00 : (avail_done ? avail_q : avail_q + 8'h01);
			ibi_req_q <= ibi_en & cfg.i3c_mode & dev_ibi_status_q & avail_done;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_rd_bad;
		ev_rstart && st_q == err_chk_pkg::ST_RX && rd_bad;
	endsequence
	sequence s_sel_nack;
		sel_after_rs ##1 sel_resp_q && !sel_ack_q;
	endsequence
	property p_par_drop;
		@(posedge link_clk) disable iff (lrst_q) par_bad && !ev_start |=> drop_q;
	endproperty
	a_par_drop: assert property (p_par_drop) else $error("parity error not dropped");
	property p_no_exec_drop;
		@(posedge link_clk) disable iff (lrst_q) drop_q && !ev_start |=> !exec_q.valid || !exec_q.write;
	endproperty
	a_no_exec_drop: assert property (p_no_exec_drop) else $error("dropped write executed");
	property p_refuse;
		@(posedge link_clk) disable iff (lrst_q) s_rd_bad |=> st_q == err_chk_pkg::ST_REFUSE;
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad read not refused");
	property p_nack;
		@(posedge link_clk) disable iff (lrst_q)
			st_q == err_chk_pkg::ST_REFUSE && !ev_stop && !ev_start && sel_after_rs |-> s_sel_nack;
	endproperty
	a_nack: assert property (p_nack) else $error("refused read acked");
	property p_crc_ok_exec;
		@(posedge link_clk) disable iff (lrst_q)
			exec_q.valid && exec_q.write && crc_on |-> $past(rx_crc_ok);
	endproperty
	a_crc_ok_exec: assert property (p_crc_ok_exec) else $error("crc mismatch executed");
	property p_tbit;
		@(posedge link_clk) disable iff (lrst_q) tx_valid |=> tbit_q == !$past(tx_last);
	endproperty
	a_tbit: assert property (p_tbit) else $error("read tbit wrong");
	property p_crc_restart;
		@(posedge link_clk) disable iff (lrst_q) ev_rstart |=> crc_q == err_chk_pkg::CRC_SEED;
	endproperty
	a_crc_restart: assert property (p_crc_restart) else $error("crc not restarted");
	property p_par_flag;
		@(posedge clk_sys) disable iff (sys_rst)
			par_ev |=> misc_error_status_reg_q[err_chk_pkg::MISC_PAR_BIT] && dev_ibi_status_q &&
				pend_q == err_chk_pkg::PEND_ERR [*2];
	endproperty
	a_par_flag: assert property (p_par_flag) else $error("parity flags not set");
	property p_pec_flag;
		@(posedge clk_sys) disable iff (sys_rst) pec_ev |=> misc_error_status_reg_q[err_chk_pkg::MISC_PEC_BIT];
	endproperty
	a_pec_flag: assert property (p_pec_flag) else $error("crc flag not set");
	property p_ibi_gate;
		@(posedge clk_sys) disable iff (sys_rst) ibi_req_q |-> $past(idle_s_q[1], 2) && $past(ibi_en);
	endproperty
	a_ibi_gate: assert property (p_ibi_gate) else $error("interrupt before bus idle");
endmodule : err_chk

// ### design/err_chk_pkg.sv
// shared constants and carriers for the bus error-check block
package err_chk_pkg;
	// ----------------------------------------------------------------
	// crc, parity and header constants
	// ----------------------------------------------------------------
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_SEED = 8'h00;
	localparam logic [6:0] IBI_HDR_ADDR = 7'h7e;
	localparam logic [3:0] PEND_ERR = 4'h1;
	localparam logic [3:0] PEND_NONE = 4'h0;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int MISC_PAR_BIT = 0;
	localparam int MISC_PEC_BIT = 1;
	localparam int CMD_HI = 7;
	localparam int CMD_LO = 5;
	localparam int CMD_RW_BIT = 4;
	localparam int ADDR_HI = 5;
	localparam int SEL_RW_BIT = 0;
	localparam logic [1:0] IDX_SEL = 2'h0;
	localparam logic [1:0] IDX_ADDR = 2'h1;
	localparam logic [1:0] IDX_CMD = 2'h2;
	localparam logic [1:0] IDX_MAX = 2'h3;
	// ----------------------------------------------------------------
	// command codes and timing
	// ----------------------------------------------------------------
	localparam logic [2:0] CMD_ONE_BYTE = 3'h0;
	localparam logic [2:0] CMD_TWO_BYTE = 3'h1;
	localparam int CLK_MHZ = 100;
	localparam int BUS_AVAIL_NS = 1000; // plain default, not a measured figure
	localparam int BUS_AVAIL_CYC = (BUS_AVAIL_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] AVAIL_LAST = 8'(BUS_AVAIL_CYC - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RX = 2'b01,
		ST_TX = 2'b10,
		ST_REFUSE = 2'b11
	} link_st_t;

	typedef struct packed {
		logic i3c_mode;
		logic par_en;
		logic pec_en;
	} cfg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] cmd;
		logic [5:0] addr;
	} exec_t;
endpackage : err_chk_pkg

// ### dv/host_model.sv
// host-side model driving link events and bytes toward the target
`timescale 1ns/1ps
module host_model (
	input wire logic link_clk, // bus-side clock
	output logic ev_start, // start pulse
	output logic ev_rstart, // repeated start pulse
	output logic ev_stop, // stop pulse
	output logic rx_valid, // byte toward target
	output logic [7:0] rx_byte, // byte value
	output logic rx_tbit, // transition bit
	output logic tx_valid, // byte leaving target
	output logic [7:0] tx_byte, // sent byte
	output logic tx_last // last sent byte
);
	// idle levels at time zero
	initial begin
		{ev_start, ev_rstart, ev_stop, rx_valid, rx_tbit, tx_valid, tx_last} = 7'h00;
		rx_byte = 8'h00;
		tx_byte = 8'h00;
	end
	// one event per call; k 0 start, 1 repeated start, 2 stop
	task automatic ev(input logic [1:0] k);
		@(posedge link_clk);
		ev_start <= (k == 2'h0);
		ev_rstart <= (k == 2'h1);
		ev_stop <= (k == 2'h2);
		@(posedge link_clk);
		{ev_start, ev_rstart, ev_stop} <= 3'h0;
	endtask : ev
	// odd parity unless asked to break it; released data shows junk
	task automatic rx(input logic [7:0] b, input logic bad);
		@(posedge link_clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
		rx_tbit <= ~^b ^ bad;
		@(posedge link_clk);
		rx_valid <= 1'b0;
		rx_byte <= ~b;
		rx_tbit <= 1'($urandom);
	endtask : rx
	// stands in for the shift engine handing out read data
	task automatic tx(input logic [7:0] b, input logic last);
		@(posedge link_clk);
		tx_valid <= 1'b1;
		tx_byte <= b;
		tx_last <= last;
		@(posedge link_clk);
		tx_valid <= 1'b0;
		tx_byte <= ~b;
		tx_last <= 1'($urandom);
	endtask : tx
endmodule : host_model

// ### dv/test_err_chk.sv
// self-checking bench for the parity and crc error checker
`timescale 1ns/1ps
module test_err_chk;
	localparam logic [6:0] DEV = 7'h31; // target address, arbitrary
	logic clk_sys = 1'b0, link_clk = 1'b0, sys_rst = 1'b1;
	err_chk_pkg::cfg_t cfg = 3'h0;
	logic bus_idle = 1'b0, ibi_en = 1'b0, ibi_done = 1'b0, clr_misc = 1'b0;
	logic ev_start, ev_rstart, ev_stop, rx_valid, rx_tbit, tx_valid, tx_last;
	logic [7:0] rx_byte, tx_byte, pec_byte_q, c, d0, d1;
	logic sel_resp_q, sel_ack_q, tbit_q, hdr_seen_q, dev_ibi_status_q, ibi_req_q;
	err_chk_pkg::exec_t exec_q, ex_seen;
	logic [1:0] misc_error_status_reg_q;
	logic [3:0] pend_q;
	logic [5:0] a;
	int n_errors = 0, samples_checked = 0, n_exec = 0, n_ack = 0, n_nack = 0, n_hdr = 0;
	int e_exec = 0, e_nack = 0, w;
	// link clock offset so its edges never line up with the system clock
	always #5 clk_sys = ~clk_sys;
	initial begin
		#3.3;
		forever #6 link_clk = ~link_clk;
	end
	err_chk uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_clk(link_clk), .cfg(cfg),
		.bus_idle(bus_idle), .ibi_en(ibi_en), .ibi_done(ibi_done), .clr_misc(clr_misc),
		.ev_start(ev_start), .ev_rstart(ev_rstart), .ev_stop(ev_stop), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .rx_tbit(rx_tbit), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_last(tx_last), .sel_resp_q(sel_resp_q), .sel_ack_q(sel_ack_q), .exec_q(exec_q),
		.tbit_q(tbit_q), .pec_byte_q(pec_byte_q), .hdr_seen_q(hdr_seen_q),
		.misc_error_status_reg_q(misc_error_status_reg_q),
		.dev_ibi_status_q(dev_ibi_status_q), .pend_q(pend_q), .ibi_req_q(ibi_req_q));
	host_model host (.link_clk(link_clk), .ev_start(ev_start), .ev_rstart(ev_rstart),
		.ev_stop(ev_stop), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_tbit(rx_tbit),
		.tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last));
	// pulse catcher: one-cycle outputs are counted on the edge they stand
	always @(posedge link_clk) begin
		if (exec_q.valid === 1'b1) begin
			n_exec <= n_exec + 1;
			ex_seen <= exec_q;
		end
		if (sel_resp_q === 1'b1 && sel_ack_q === 1'b1) n_ack <= n_ack + 1;
		if (sel_resp_q === 1'b1 && sel_ack_q === 1'b0) n_nack <= n_nack + 1;
		if (hdr_seen_q === 1'b1) n_hdr <= n_hdr + 1;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [7:0] crc8(input logic [7:0] cr, input logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = cr[7] ^ b[i];
			cr = {cr[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return cr;
	endfunction : crc8
	task automatic settle;
		repeat (30) @(posedge clk_sys);
	endtask : settle
	// start, select, address, command, crc when enabled; bp picks a bad byte
	task automatic pkt(input logic [3:0] cw, input int bp, input logic bad_crc);
		logic [7:0] b [3];
		b[0] = {DEV, 1'b0};
		b[1] = {2'h0, a};
		b[2] = {cw, 4'h0};
		c = 8'h00;
		host.ev(2'h0);
		for (int i = 0; i < 3; i++) begin
			c = crc8(c, b[i]);
			host.rx(b[i], i == bp);
		end
		if (cfg.pec_en) host.rx(c ^ {7'h00, bad_crc}, 1'b0);
	endtask : pkt
	task automatic sys_pulse(input logic clr);
		@(posedge clk_sys);
		clr_misc <= clr;
		ibi_done <= ~clr;
		@(posedge clk_sys);
		{clr_misc, ibi_done} <= 2'h0;
	endtask : sys_pulse
	// random strobes while every flag is clear must leave the flags clear
	task automatic noise;
		@(posedge clk_sys);
		{bus_idle, ibi_en, ibi_done, clr_misc} <= 4'($urandom);
		@(posedge clk_sys);
		{bus_idle, ibi_done, clr_misc} <= 3'h0;
	endtask : noise
	task automatic status(input logic [1:0] m, input logic d, input logic [3:0] p);
		settle();
		chk("misc status", 16'(misc_error_status_reg_q), 16'(m));
		chk("device status", 16'(dev_ibi_status_q), 16'(d));
		chk("pending bits", 16'(pend_q), 16'(p));
		chk("exec count", 16'(n_exec), 16'(e_exec));
	endtask : status
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : test_done
	// hang guard, well past the longest sequence
	initial begin
		#900000;
		n_errors++;
		test_done();
	end
	// main sequence
	initial begin
		void'($urandom(32'h5a4a));
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cfg <= 3'b110;
		settle();
		// broken parity on the select byte is not looked at
		a = 6'($urandom);
		pkt(4'h0, 0, 1'b0);
		host.ev(2'h2);
		e_exec++;
		status(2'h0, 1'b0, 4'h0);
		chk("exec kind", 16'({ex_seen.write, ex_seen.cmd}), 16'h0008);
		// parity error in the address byte drops the packet
		pkt(4'h0, 1, 1'b0);
		host.ev(2'h2);
		status(2'h1, 1'b1, 4'h1);
		ibi_en <= 1'b1;
		bus_idle <= 1'b1;
		for (w = 0; w < 400 && ibi_req_q !== 1'b1; w++) @(posedge clk_sys);
		chk("interrupt request", 16'(ibi_req_q), 16'h0001);
		sys_pulse(1'b0);
		status(2'h1, 1'b0, 4'h0);
		chk("interrupt dropped", 16'(ibi_req_q), 16'h0000);
		sys_pulse(1'b1);
		bus_idle <= 1'b0;
		status(2'h0, 1'b0, 4'h0);
		// crc on: both write commands with good crc, then a bad crc, then a parity error
		cfg <= 3'b111;
		settle();
		foreach (d0[i]) if (i < 2) begin
			noise();
			a = 6'($urandom);
			pkt({2'h0, i[0], 1'b0}, -1, 1'b0);
			host.ev(2'h2);
			e_exec++;
			status(2'h0, 1'b0, 4'h0);
			chk("exec fields", 16'(ex_seen), {5'h00, 2'h3, 2'h0, i[0], a});
		end
		pkt(4'h0, -1, 1'b1);
		host.ev(2'h2);
		status(2'h2, 1'b1, 4'h1);
		pkt(4'h0, 2, 1'b0);
		host.ev(2'h2);
		status(2'h3, 1'b1, 4'h1);
		sys_pulse(1'b1);
		// clean two-byte read with crc appended on the way back
		a = 6'($urandom);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		pkt(4'h3, -1, 1'b0);
		host.ev(2'h1);
		host.rx({DEV, 1'b1}, 1'b0);
		host.tx(d0, 1'b0);
		#1 chk("tbit continue", 16'(tbit_q), 16'h0001);
		host.tx(d1, 1'b1);
		#1 chk("tbit end", 16'(tbit_q), 16'h0000);
		chk("sent crc", 16'(pec_byte_q), 16'(crc8(crc8(crc8(8'h00, {DEV, 1'b1}), d0), d1)));
		// a further read after a finished one is answered again
		host.ev(2'h1);
		host.rx({DEV, 1'b1}, 1'b0);
		e_exec++;
		host.ev(2'h2);
		e_exec++;
		status(2'h0, 1'b0, 4'h0);
		chk("read ack", 16'(n_ack), 16'h0002);
		chk("read exec", 16'(ex_seen), {5'h00, 2'h2, 3'h1, a});
		// failed reads: parity without crc, then crc error; each retry refused
		for (int k = 0; k < 2; k++) begin
			cfg <= {2'h3, k[0]};
			settle();
			pkt(4'h1, k ? -1 : 1, k[0]);
			repeat (2) begin
				host.ev(2'h1);
				host.rx({DEV, 1'b1}, 1'b0);
				e_nack++;
			end
			host.ev(2'h2);
			status(k ? 2'h2 : 2'h1, 1'b1, 4'h1);
			chk("nack count", 16'(n_nack), 16'(e_nack));
			sys_pulse(1'b1);
		end
		// broadcast header is flagged
		host.ev(2'h0);
		host.rx({err_chk_pkg::IBI_HDR_ADDR, 1'b0}, 1'b0);
		host.ev(2'h2);
		settle();
		chk("header seen", 16'(n_hdr), 16'h0001);
		// plain two-wire mode: no parity, no crc, no command decode
		cfg <= {1'b0, 2'($urandom)};
		settle();
		a = 6'($urandom);
		pkt(4'($urandom), int'($urandom % 3), 1'b1);
		host.ev(2'h2);
		e_exec++;
		status(2'h0, 1'b0, 4'h0);
		chk("plain exec", 16'(ex_seen), {5'h00, 2'h3, 3'h0, a});
		test_done();
	end
endmodule : test_err_chk
